//--- filter_wheel_pkg.sv
// constants, encodings and helpers shared by the filter wheel positioner and its serializer
// assumes a single 10 MHz clock for every block that imports it
package filter_wheel_pkg;

    // =====================================================================
    // timing
    localparam int CLK_MHZ = 10;
    localparam int STEP_TIME_US = 2000;
    localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
    localparam int PAIR_WINDOW_STEPS = 3;
    localparam int WIN_W = 3;

    // =====================================================================
    // video
    localparam int WORD_W = 8;
    localparam int EXPOSE_WORDS = 64;

    // =====================================================================
    // wheel positions, ascending in the turning direction
    localparam logic [1:0] POS_HOME = 2'h0;
    localparam logic [1:0] POS_RED = 2'h1;
    localparam logic [1:0] POS_GREEN = 2'h2;
    localparam logic [1:0] POS_BLUE = 2'h3;

    // =====================================================================
    // sense code
    localparam logic [1:0] SENSE_NONE = 2'h0;
    localparam logic [1:0] SENSE_SINGLE = 2'h1;
    localparam logic [1:0] SENSE_DOUBLE = 2'h2;
    localparam logic [1:0] PULSE_PAIR = 2'h2;

    // =====================================================================
    // coil patterns, two-phase-on full step
    localparam logic [3:0] COIL_STEP0 = 4'h3;
    localparam logic [3:0] COIL_STEP1 = 4'h6;
    localparam logic [3:0] COIL_STEP2 = 4'hC;
    localparam logic [3:0] COIL_STEP3 = 4'h9;

    typedef enum logic [3:0] {
        ST_HOMING = 4'h1,
        ST_IDLE = 4'h2,
        ST_MOVE = 4'h4,
        ST_EXPOSE = 4'h8
    } wheel_state_type;

    function automatic logic [3:0] coil_pattern(input logic [1:0] ph);
        logic [3:0] pat;
        pat = COIL_STEP0;
        case (ph)
            2'h0: pat = COIL_STEP0;
            2'h1: pat = COIL_STEP1;
            2'h2: pat = COIL_STEP2;
            2'h3: pat = COIL_STEP3;
            default: pat = COIL_STEP0;
        endcase
        return pat;
    endfunction

endpackage

//--- video_if.sv
// exposure control link between the positioner and the video serializer
// assumes both ends share one clock
`timescale 1ns/1ns
interface video_if;
    logic run;
    logic done;
    modport ctl (output run, input done);
    modport ser (input run, output done);
endinterface

//--- video_serializer.sv
// latches parallel video memory words and shifts them out as a serial video bit
// assumes the word source answers word_req with word_valid on the same clock
`timescale 1ns/1ns
module video_serializer #(
    parameter int WORD_W = filter_wheel_pkg::WORD_W,
    parameter int EXPOSE_WORDS = filter_wheel_pkg::EXPOSE_WORDS
) (
    input wire logic clk,
    input wire logic rstn,
    video_if.ser vid,
    input wire logic word_valid,
    input wire logic [WORD_W-1:0] word_in,
    output logic word_req,
    output logic video_out
);
    import filter_wheel_pkg::*;

    localparam int BW = $clog2(WORD_W + 1);
    localparam int CW = $clog2(EXPOSE_WORDS + 1);
    localparam logic [BW-1:0] BITS_FULL = BW'(WORD_W);
    localparam logic [CW-1:0] WORDS_LAST = CW'(EXPOSE_WORDS);

    typedef struct packed {
        logic [WORD_W-1:0] latch;
        logic [BW-1:0] bits;
        logic [CW-1:0] words;
        logic req;
        logic video;
        logic done;
    } ser_reg_type;

    ser_reg_type r_ff;
    ser_reg_type nxt_r;

    // =====================================================================
    // shifter
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (!vid.run) begin
            nxt_r.bits = '0;
            nxt_r.words = '0;
            nxt_r.req = 1'b0;
            nxt_r.video = 1'b0;
        end else if (r_ff.bits != '0) begin
            nxt_r.video = r_ff.latch[WORD_W-1];
            nxt_r.latch = r_ff.latch << 1;
            nxt_r.bits = r_ff.bits - 1'b1;
            if (r_ff.bits == BW'(1) && r_ff.words == WORDS_LAST) begin
                nxt_r.done = 1'b1;
            end
        end else begin
            nxt_r.video = 1'b0;
            if (r_ff.words == WORDS_LAST) begin
                nxt_r.req = 1'b0;
            end else if (r_ff.req && word_valid) begin
                nxt_r.latch = word_in;
                nxt_r.bits = BITS_FULL;
                nxt_r.words = r_ff.words + 1'b1;
                nxt_r.req = 1'b0;
            end else begin
                nxt_r.req = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign word_req = r_ff.req;
    assign video_out = r_ff.video;
    assign vid.done = r_ff.done;

    // =====================================================================
    // checks
    AST_LOAD: assert property (@(posedge clk) disable iff (!rstn)
        (vid.run && r_ff.req && word_valid && r_ff.bits == '0 && r_ff.words != WORDS_LAST)
        |=> (r_ff.bits == BITS_FULL && r_ff.latch == $past(word_in)))
        else $error("video word not latched on handshake");

endmodule // video_serializer

//--- filter_wheel_positioner.sv
// filter wheel homing, colour positioning and exposure sequencing
// assumes one 10 MHz clock; the notch sensor input is asynchronous
// How it works
// - home the wheel before any exposure
// - step clockwise only, always
// - a notch pulse pair marks home
// - publish a two-bit sense code
// - stop stepping once home is seen while homing
// - a single pulse marks a filter notch
// - stop when the requested filter arrives
// - step pulses pass a coil phasing stage
// - expose only after filter is in place
// - colours go red, green, then blue
// - higher filter: step straight forward
// - lower filter: step through home first
// - latch video words, shift them out
// - blank video at exposure end
// - repeat exposure for every colour
`timescale 1ns/1ns
module filter_wheel_positioner #(
    parameter int STEP_CYCLES_P = filter_wheel_pkg::STEP_CYCLES,
    parameter int PAIR_WINDOW_STEPS_P = filter_wheel_pkg::PAIR_WINDOW_STEPS,
    parameter int WORD_W = filter_wheel_pkg::WORD_W,
    parameter int EXPOSE_WORDS = filter_wheel_pkg::EXPOSE_WORDS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wheel_notch_pulse,
    input wire logic expose_valid,
    input wire logic [1:0] expose_color,
    input wire logic word_valid,
    input wire logic [WORD_W-1:0] word_in,
    output logic word_req,
    output logic video_out,
    output logic [3:0] coil_drive,
    output logic step_pulse,
    output logic [1:0] sense_code,
    output logic [1:0] filter_index,
    output logic ready,
    output logic exposure_done,
    output logic picture_done,
    output logic sequence_error
);
    import filter_wheel_pkg::*;

    localparam int DIV_W = $clog2(STEP_CYCLES_P + 1);
    localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(STEP_CYCLES_P - 1);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(PAIR_WINDOW_STEPS_P);
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(1);

    typedef struct packed {
        wheel_state_type st;
        logic [DIV_W-1:0] div;
        logic sync1;
        logic sync2;
        logic sync3;
        logic [1:0] pulses;
        logic [WIN_W-1:0] win;
        logic [1:0] sense;
        logic [1:0] pos;
        logic [1:0] target;
        logic [1:0] next_color;
        logic [1:0] phase;
        logic [3:0] coils;
        logic step;
        logic homed;
        logic run;
        logic ready;
        logic exp_done;
        logic pic_done;
        logic seq_err;
    } wheel_reg_type;

    wheel_reg_type r_ff;
    wheel_reg_type nxt_r;
    logic tick;
    logic resolved;
    logic home_seen;
    logic [1:0] nxt_phase;

    video_if vid();

    video_serializer #(
        .WORD_W(WORD_W),
        .EXPOSE_WORDS(EXPOSE_WORDS)
    ) u_serializer (
        .clk(clk),
        .rstn(rstn),
        .vid(vid),
        .word_valid(word_valid),
        .word_in(word_in),
        .word_req(word_req),
        .video_out(video_out)
    );

    // =====================================================================
    // next state
    always_comb begin
        nxt_r = r_ff;
        nxt_r.sync1 = wheel_notch_pulse;
        nxt_r.sync2 = r_ff.sync1;
        nxt_r.sync3 = r_ff.sync2;
        nxt_r.step = 1'b0;
        nxt_r.exp_done = 1'b0;
        nxt_r.pic_done = 1'b0;
        nxt_r.seq_err = 1'b0;
        nxt_phase = r_ff.phase + 2'h1;
        tick = (r_ff.div == '0);
        nxt_r.div = tick ? DIV_LOAD : r_ff.div - 1'b1;
        resolved = 1'b0;

        // count notch pulses inside a window of a few steps
        if (r_ff.sync2 && !r_ff.sync3) begin
            if (r_ff.pulses != PULSE_PAIR) begin
                nxt_r.pulses = r_ff.pulses + 2'h1;
            end
            nxt_r.win = WIN_LOAD;
        end else if (tick && r_ff.win != '0) begin
            nxt_r.win = r_ff.win - 1'b1;
            if (r_ff.win == WIN_LAST) begin
                resolved = 1'b1;
                nxt_r.pulses = '0;
                nxt_r.sense = (r_ff.pulses == PULSE_PAIR) ? SENSE_DOUBLE : SENSE_SINGLE;
            end
        end
        home_seen = resolved && (r_ff.pulses == PULSE_PAIR);
        if (home_seen) begin
            nxt_r.pos = POS_HOME;
        end else if (resolved && r_ff.homed) begin
            nxt_r.pos = r_ff.pos + 2'h1;
        end

        case (r_ff.st)
            ST_HOMING: begin
                if (home_seen) begin
                    nxt_r.st = ST_IDLE;
                    nxt_r.homed = 1'b1;
                end
            end
            ST_IDLE: begin
                if (expose_valid) begin
                    if (expose_color != r_ff.next_color) begin
                        nxt_r.seq_err = 1'b1;
                    end else if (expose_color == r_ff.pos) begin
                        nxt_r.target = expose_color;
                        nxt_r.st = ST_EXPOSE;
                        nxt_r.run = 1'b1;
                    end else begin
                        nxt_r.target = expose_color;
                        nxt_r.st = ST_MOVE;
                    end
                end
            end
            ST_MOVE: begin
                if (resolved && nxt_r.pos == r_ff.target) begin
                    nxt_r.st = ST_EXPOSE;
                    nxt_r.run = 1'b1;
                end
            end
            ST_EXPOSE: begin
                if (vid.done) begin
                    nxt_r.run = 1'b0;
                    nxt_r.st = ST_IDLE;
                    nxt_r.exp_done = 1'b1;
                    if (r_ff.target == POS_BLUE) begin
                        nxt_r.pic_done = 1'b1;
                        nxt_r.next_color = POS_RED;
                    end else begin
                        nxt_r.next_color = r_ff.target + 2'h1;
                    end
                end
            end
            default: begin
                nxt_r.st = ST_HOMING;
                nxt_r.homed = 1'b0;
                nxt_r.run = 1'b0;
            end
        endcase

        // one direction only; the stepping state holds while the wheel travels
        if (tick && nxt_r.st == r_ff.st && (r_ff.st == ST_HOMING || r_ff.st == ST_MOVE)) begin
            nxt_r.step = 1'b1;
            nxt_r.phase = nxt_phase;
            nxt_r.coils = coil_pattern(nxt_phase);
        end
        nxt_r.ready = (nxt_r.st == ST_IDLE);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_ff <= '0;
            r_ff.st <= ST_HOMING;
            r_ff.next_color <= POS_RED;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign vid.run = r_ff.run;
    assign coil_drive = r_ff.coils;
    assign step_pulse = r_ff.step;
    assign sense_code = r_ff.sense;
    assign filter_index = r_ff.pos;
    assign ready = r_ff.ready;
    assign exposure_done = r_ff.exp_done;
    assign picture_done = r_ff.pic_done;
    assign sequence_error = r_ff.seq_err;

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_exposure_end;
        vid.done;
    endsequence

    sequence s_dark;
        ##2 !video_out;
    endsequence

    AST_HOME_FIRST: assert property (!r_ff.homed |-> r_ff.st == ST_HOMING && !r_ff.run)
        else $error("exposure state reached before homing");
    AST_CW_ONLY: assert property (r_ff.step |-> r_ff.phase == $past(r_ff.phase) + 2'h1)
        else $error("phase did not advance forward on a step");
    AST_HOME_STOP: assert property ((r_ff.st == ST_HOMING && home_seen)
        |=> (r_ff.st == ST_IDLE && r_ff.pos == POS_HOME) ##1 !r_ff.step)
        else $error("home pair did not stop the wheel at home");
    AST_SENSE_PAIR: assert property ((resolved && r_ff.pulses == PULSE_PAIR)
        |=> r_ff.sense == SENSE_DOUBLE)
        else $error("pulse pair not reported as double sense");
    AST_NO_STEP_REST: assert property ((r_ff.st == ST_IDLE || r_ff.st == ST_EXPOSE)
        |=> !r_ff.step)
        else $error("step issued while wheel should rest");
    AST_INDEX_ADVANCE: assert property ((resolved && !home_seen && r_ff.homed)
        |=> r_ff.pos == $past(r_ff.pos) + 2'h1 && r_ff.sense == SENSE_SINGLE)
        else $error("single notch did not advance the index");
    AST_MOVE_UNTIL_THERE: assert property (r_ff.st == ST_MOVE |-> r_ff.pos != r_ff.target)
        else $error("still moving with the filter in place");
    AST_COIL_PHASE: assert property (r_ff.step |-> r_ff.coils == coil_pattern(r_ff.phase))
        else $error("coil pattern does not match phase");
    AST_EXPOSE_IN_PLACE: assert property (r_ff.run |-> r_ff.pos == r_ff.target)
        else $error("exposure running away from its filter");
    AST_ORDER: assert property ((r_ff.st == ST_IDLE && expose_valid
        && expose_color != r_ff.next_color) |=> r_ff.seq_err && r_ff.st == ST_IDLE)
        else $error("out of order colour was accepted");
    AST_BLANK: assert property (s_exposure_end |-> s_dark)
        else $error("video not blanked after exposure");
    AST_WRAP: assert property (r_ff.pic_done |-> $past(r_ff.target) == POS_BLUE
        && r_ff.next_color == POS_RED)
        else $error("picture end not after blue");

endmodule // filter_wheel_positioner

//--- wheel_motor_model.sv
// stepper motor and notch sensor of a 32-step filter wheel
// assumes coil_drive and step_pulse are registered on rising clk edges
`timescale 1ns/1ns
module wheel_motor_model #(
    parameter int START_POS = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] coil_drive,
    input wire logic step_pulse,
    output logic wheel_notch_pulse,
    output int pos,
    output int bad_steps
);
    logic [3:0] last_coil;

    function automatic logic [3:0] next_coil(input logic [3:0] c);
        case (c)
            4'h3: return 4'h6;
            4'h6: return 4'hC;
            4'hC: return 4'h9;
            default: return 4'h3;
        endcase
    endfunction

    initial begin
        pos = START_POS;
        bad_steps = 0;
    end

    // home is a notch pair two steps apart, then one notch per filter
    assign wheel_notch_pulse = (pos == 0) || (pos == 2) || (pos == 8) || (pos == 16) || (pos == 24);

    // =====================================================================
    // rotor: any coil change turns it one step clockwise; an out-of-order phase or a change without step_pulse counts as a bad step
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_coil <= 4'h0;
        end else if (coil_drive !== last_coil) begin
            if (last_coil !== 4'h0 && coil_drive !== next_coil(last_coil)) begin
                bad_steps <= bad_steps + 1;
            end
            if (step_pulse !== 1'b1) begin
                bad_steps <= bad_steps + 1;
            end
            pos <= (pos + 1) % 32;
            last_coil <= coil_drive;
        end
    end
endmodule // wheel_motor_model

//--- filter_wheel_positioner_test.sv
// self-checking bench of the filter wheel positioner against a wheel model
// assumes the package constants and a video source that always has a word
`timescale 1ns/1ns
module filter_wheel_positioner_test;
    import filter_wheel_pkg::*;
    typedef struct packed {
        logic [1:0] color;
        logic [7:0] word;
        logic back_home;
        logic last;
    } row_type;
    row_type rows [4] = '{'{POS_RED, 8'hA5, 1'b0, 1'b0}, '{POS_GREEN, 8'h3C, 1'b0, 1'b0},
        '{POS_BLUE, 8'hF0, 1'b0, 1'b1}, '{POS_RED, 8'h81, 1'b1, 1'b0}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic expose_valid = 1'b0;
    logic [1:0] expose_color = 2'h0;
    logic [7:0] word_in = 8'h00;
    logic word_req, video_out, step_pulse, ready, exposure_done, picture_done, sequence_error;
    logic wheel_notch_pulse, saw_home;
    logic [3:0] coil_drive;
    logic [1:0] sense_code, filter_index;
    logic [1:0] prev_idx = 2'h0;
    int pos, bad_steps;
    int fail_count = 0;
    int n_compared = 0;

    always #50 clk = ~clk;

    filter_wheel_positioner #(.STEP_CYCLES_P(8), .PAIR_WINDOW_STEPS_P(3), .WORD_W(8),
        .EXPOSE_WORDS(2)) filter_wheel_positioner_inst (.clk(clk), .rstn(rstn),
        .wheel_notch_pulse(wheel_notch_pulse), .expose_valid(expose_valid),
        .expose_color(expose_color), .word_valid(1'b1), .word_in(word_in),
        .word_req(word_req), .video_out(video_out), .coil_drive(coil_drive),
        .step_pulse(step_pulse), .sense_code(sense_code), .filter_index(filter_index),
        .ready(ready), .exposure_done(exposure_done), .picture_done(picture_done),
        .sequence_error(sequence_error));

    wheel_motor_model wheel_motor_model_inst (.clk(clk), .rstn(rstn), .coil_drive(coil_drive),
        .step_pulse(step_pulse), .wheel_notch_pulse(wheel_notch_pulse), .pos(pos),
        .bad_steps(bad_steps));

    // notes when the index falls back to home after a command is taken
    always @(posedge clk) begin
        if (expose_valid) saw_home <= 1'b0;
        else if (prev_idx != 2'h0 && filter_index == 2'h0) saw_home <= 1'b1;
        prev_idx <= filter_index;
    end

    // =====================================================================
    // tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared=%0d failed=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic send(input logic [1:0] color);
        @(negedge clk);
        expose_valid = 1'b1;
        expose_color = color;
        @(negedge clk);
        expose_valid = 1'b0;
    endtask

    task automatic count_steps(output int steps);
        steps = 0;
        repeat (40) begin
            @(negedge clk);
            if (step_pulse === 1'b1) steps++;
        end
    endtask

    task automatic wait_word();
        int n;
        n = 0;
        while (word_req !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic run_row(input row_type r);
        logic [7:0] got;
        int n;
        word_in = r.word;
        send(r.color);
        wait_word();
        check(16'(filter_index), 16'(r.color));
        check(16'(sense_code), 16'(SENSE_SINGLE));
        check(16'(saw_home), 16'(r.back_home));
        repeat (2) begin
            wait_word();
            repeat (2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                @(negedge clk);
                got = {got[6:0], video_out};
            end
            check(16'(got), 16'(r.word));
        end
        n = 0;
        while (exposure_done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check(16'(exposure_done), 16'h1);
        check(16'(picture_done), 16'(r.last));
        check(16'(ready), 16'h1);
        n = 0;
        repeat (20) begin
            @(negedge clk);
            if (video_out !== 1'b0) n++;
        end
        check(16'(n), 16'h0);
    endtask

    // =====================================================================
    // main sequence
    initial begin
        int steps;
        repeat (10) @(negedge clk);
        check(16'({ready, coil_drive, filter_index}), 16'h0);
        rstn = 1'b1;
        send(POS_RED);
        repeat (20) @(negedge clk);
        check(16'({ready, word_req}), 16'h0);
        steps = 0;
        while (ready !== 1'b1 && steps < 2000) begin
            @(negedge clk);
            steps++;
        end
        check(16'(filter_index), 16'(POS_HOME));
        check(16'(sense_code), 16'(SENSE_DOUBLE));
        count_steps(steps);
        check(16'(steps), 16'h0);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        count_steps(steps);
        check(16'(steps), 16'h0);
        foreach (rows[i]) begin
            if (i < 2) begin
                send(i == 0 ? POS_BLUE : POS_HOME);
                check(16'({sequence_error, ready}), 16'h3);
            end
        end
        run_row('{POS_GREEN, 8'hC3, 1'b0, 1'b0});
        check(16'(bad_steps), 16'h0);
        // reset in mid-run: the wheel must home again from where it rests
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        check(16'({ready, step_pulse, sense_code, filter_index}), 16'h0);
        rstn = 1'b1;
        steps = 0;
        while (ready !== 1'b1 && steps < 2000) begin
            @(negedge clk);
            steps++;
        end
        check(16'({filter_index, sense_code}), 16'({POS_HOME, SENSE_DOUBLE}));
        run_row('{POS_RED, 8'h5A, 1'b0, 1'b0});
        check(16'(bad_steps), 16'h0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // filter_wheel_positioner_test
